//--- rtl/tsl_cfg.svh
// Widths and fixed figures of the table shift and logic copy engine
`ifndef TSL_CFG_SVH
`define TSL_CFG_SVH

// ----------------------------------------
// Word and table geometry
// ----------------------------------------
`define TSL_WORD_W   16
`define TSL_BIT_W    4
`define TSL_LEN_W    8
`define TSL_ADDR_W   16
`define TSL_IDX_W    11

// ----------------------------------------
// Shift count operand, octal digits one per nibble
// ----------------------------------------
`define TSL_OPND_W   16
`define TSL_DIG_W    3
`define TSL_NIB_W    4
`define TSL_CNT_W    12

`endif

//--- rtl/tsl_pkg.sv
// Types shared by the table shift and logic copy engine
`include "tsl_cfg.svh"

package tsl_pkg;

    // ----------------------------------------
    // Sequencer states, Gray along the path except the done to rda step
    // ----------------------------------------
    typedef enum logic [2:0] {
        tsl_idle  = 3'h0,
        tsl_peek  = 3'h1,
        tsl_pwait = 3'h3,
        tsl_rda   = 3'h2,
        tsl_rdb   = 3'h6,
        tsl_cap   = 3'h7,
        tsl_wrt   = 3'h5,
        tsl_done  = 3'h4
    } tsl_state_t;

    // ----------------------------------------
    // Operations
    // ----------------------------------------
    typedef enum logic [2:0] {
        tsl_table_bit_shift_left  = 3'h0,
        tsl_table_bit_shift_right = 3'h1,
        tsl_masked_and_copy       = 3'h2,
        tsl_masked_or_copy        = 3'h3,
        tsl_masked_xor_copy       = 3'h4
    } tsl_op_t;

    typedef struct packed {
        tsl_op_t                 op;
        logic [`TSL_LEN_W-1:0]   stack_len;
        logic [`TSL_ADDR_W-1:0]  acc_start;
        logic [`TSL_WORD_W-1:0]  acc_pattern;
        logic [`TSL_OPND_W-1:0]  operand;
    } tsl_cmd_t;

    typedef struct packed {
        logic                    rd;
        logic                    we;
        logic [`TSL_ADDR_W-1:0]  addr;
        logic [`TSL_WORD_W-1:0]  wdata;
    } tsl_mem_t;

    typedef struct packed {
        logic range_error_flag;
        logic discarded_one_flag;
    } tsl_flags_t;

    typedef struct packed {
        tsl_state_t              st;
        tsl_op_t                 op;
        logic [`TSL_LEN_W-1:0]   len;
        logic [`TSL_ADDR_W-1:0]  src;
        logic [`TSL_ADDR_W-1:0]  dst;
        logic [`TSL_WORD_W-1:0]  pat;
        logic [`TSL_CNT_W-1:0]   cnt;
        logic [`TSL_LEN_W:0]     k;
        logic [`TSL_LEN_W:0]     wcnt;
        logic [`TSL_WORD_W-1:0]  wa;
        logic [`TSL_WORD_W-1:0]  wb;
        logic                    pbit;
        logic                    busy;
        logic                    done;
        tsl_flags_t              flags;
        tsl_mem_t                mem;
    } tsl_regs_t;

endpackage : tsl_pkg

//--- rtl/tsl_engine.sv
// Table bit shift and masked table copy engine working on 16-bit word tables
//
// Functional notes
// - Left shift moves all table bits toward higher positions by the count.
// - Right shift moves all table bits toward lower positions by the count.
// - Bits leaving one word enter the opposite end of the neighbour word.
// - Bits shifted past table ends are dropped; vacated positions fill with zeros.
// - Right shift drops low bits of first word, zeros enter last word top.
// - Words are 16 bits; bit index starts in first word and runs upward.
// - Shift count comes from the operand and is read as octal.
// - Range error flag rises when count exceeds total table bits.
// - Discarded-one flag rises when the final dropped bit is one.
// - Flags hold only until scan end or next operation driving them.
// - AND copy writes each source word ANDed with the pattern.
// - OR copy writes each source word ORed with the pattern.
// - XOR copy writes each source word XORed with the pattern.
// - Copy operand is destination start; destination has source word count.
// - An operation restarts on each return to idle while its enable is true.
`timescale 1ns/1ps
`include "tsl_cfg.svh"

module tsl_engine (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // Operation request from the scan controller
    input  wire logic                   cmd_valid,
    input  wire tsl_pkg::tsl_cmd_t      cmd,
    input  wire logic                   scan_end,
    // Data memory
    output tsl_pkg::tsl_mem_t           mem,
    input  wire logic [`TSL_WORD_W-1:0] mem_rdata,
    // Status
    output logic                        busy,
    output logic                        done,
    output tsl_pkg::tsl_flags_t         flags
);

    tsl_pkg::tsl_regs_t s_reg;
    tsl_pkg::tsl_regs_t s_next;

    // ----------------------------------------
    // Index arithmetic
    // ----------------------------------------
    logic signed [`TSL_IDX_W-1:0] ia;
    logic signed [`TSL_IDX_W-1:0] ib;
    logic signed [`TSL_IDX_W-1:0] kk;
    logic signed [`TSL_IDX_W-1:0] qq;
    logic signed [`TSL_IDX_W-1:0] nn;
    logic                         va;
    logic                         vb;
    logic                         is_left;
    logic                         is_right;
    logic                         is_shift;
    logic [`TSL_BIT_W-1:0]        rr;
    logic [`TSL_CNT_W:0]          tot_bits;
    logic [`TSL_CNT_W:0]          pos;
    logic                         pvalid;
    logic                         last;
    logic [`TSL_WORD_W-1:0]       word;
    logic [`TSL_CNT_W-1:0]        oct_cnt;

    assign is_left  = (s_reg.op == tsl_pkg::tsl_table_bit_shift_left);
    assign is_right = (s_reg.op == tsl_pkg::tsl_table_bit_shift_right);
    assign is_shift = is_left | is_right;
    assign rr       = s_reg.cnt[`TSL_BIT_W-1:0];
    assign kk       = `TSL_IDX_W'(s_reg.k);
    assign qq       = `TSL_IDX_W'(s_reg.cnt[`TSL_CNT_W-1:`TSL_BIT_W]);
    assign nn       = `TSL_IDX_W'(s_reg.len);
    assign tot_bits = {1'b0, s_reg.len, {`TSL_BIT_W{1'b0}}};

    // Source words feeding output word k; outside the table they read as zero
    always_comb begin
        ia = kk;
        ib = kk;
        if (is_right) begin
            ia = kk + qq;
            ib = kk + qq + `TSL_IDX_W'(1);
        end else if (is_left) begin
            ia = kk - qq;
            ib = kk - qq - `TSL_IDX_W'(1);
        end
    end

    assign va = (ia >= 0) && (ia < nn);
    assign vb = is_shift && (ib >= 0) && (ib < nn) && (rr != '0);

    // Last bit dropped: right shift loses bit count-1, left loses bit total-count
    assign pvalid = (s_reg.cnt != '0) && ({1'b0, s_reg.cnt} <= tot_bits);
    assign pos    = is_right ? ({1'b0, s_reg.cnt} - `TSL_CNT_W'(1))
                             : (tot_bits - {1'b0, s_reg.cnt});
    assign last   = is_left ? (s_reg.k == '0)
                            : (s_reg.k == {1'b0, s_reg.len - `TSL_LEN_W'(1)});

    // Octal operand: one digit per nibble, the top bit of each nibble ignored
    always_comb begin
        oct_cnt = '0;
        for (int d = 0; d < `TSL_CNT_W / `TSL_DIG_W; d++) begin
            oct_cnt[d*`TSL_DIG_W +: `TSL_DIG_W] = cmd.operand[d*`TSL_NIB_W +: `TSL_DIG_W];
        end
    end

    // ----------------------------------------
    // Word combine
    // ----------------------------------------
    always_comb begin
        word = s_reg.wa;
        case (s_reg.op)
            tsl_pkg::tsl_table_bit_shift_left: begin
                word = (s_reg.wa << rr) | (s_reg.wb >> (`TSL_BIT_W'(0) - rr));
            end
            tsl_pkg::tsl_table_bit_shift_right: begin
                word = (s_reg.wa >> rr) | (s_reg.wb << (`TSL_BIT_W'(0) - rr));
            end
            tsl_pkg::tsl_masked_and_copy: begin
                word = s_reg.wa & s_reg.pat;
            end
            tsl_pkg::tsl_masked_or_copy: begin
                word = s_reg.wa | s_reg.pat;
            end
            tsl_pkg::tsl_masked_xor_copy: begin
                word = s_reg.wa ^ s_reg.pat;
            end
            default: begin
                word = s_reg.wa;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        s_next        = s_reg;
        s_next.done   = 1'b0;
        s_next.mem.rd = 1'b0;
        s_next.mem.we = 1'b0;
        if (scan_end) begin
            s_next.flags = '0;
        end
        case (s_reg.st)
            tsl_pkg::tsl_idle: begin
                // Taken on every return to idle while the enable is up, so a level repeats the work
                if (cmd_valid) begin
                    s_next.op   = cmd.op;
                    s_next.len  = cmd.stack_len;
                    s_next.src  = cmd.acc_start;
                    s_next.pat  = cmd.acc_pattern;
                    s_next.dst  = cmd.operand;
                    s_next.cnt  = oct_cnt;
                    s_next.busy = 1'b1;
                    s_next.wcnt = '0;
                    s_next.pbit = 1'b0;
                    s_next.k    = (cmd.op == tsl_pkg::tsl_table_bit_shift_left)
                                ? {1'b0, cmd.stack_len - `TSL_LEN_W'(1)} : '0;
                    if (cmd.stack_len == '0) begin
                        s_next.st   = tsl_pkg::tsl_done;
                        s_next.done = 1'b1;
                        if (cmd.op == tsl_pkg::tsl_table_bit_shift_left ||
                            cmd.op == tsl_pkg::tsl_table_bit_shift_right) begin
                            s_next.flags.range_error_flag   = (oct_cnt != '0);
                            s_next.flags.discarded_one_flag = 1'b0;
                        end
                    end else if (cmd.op == tsl_pkg::tsl_table_bit_shift_left ||
                                 cmd.op == tsl_pkg::tsl_table_bit_shift_right) begin
                        s_next.st = tsl_pkg::tsl_peek;
                    end else begin
                        s_next.st = tsl_pkg::tsl_rda;
                    end
                end
            end
            tsl_pkg::tsl_peek: begin
                s_next.mem.rd   = pvalid;
                s_next.mem.addr = s_reg.src + `TSL_ADDR_W'(pos[`TSL_CNT_W:`TSL_BIT_W]);
                s_next.st       = tsl_pkg::tsl_pwait;
            end
            tsl_pkg::tsl_pwait: begin
                s_next.st = tsl_pkg::tsl_rda;
            end
            tsl_pkg::tsl_rda: begin
                // Only the first pass finds the peeked word on the read bus
                if (is_shift && s_reg.wcnt == '0) begin
                    s_next.pbit = pvalid & mem_rdata[pos[`TSL_BIT_W-1:0]];
                end
                s_next.mem.rd   = va;
                s_next.mem.addr = s_reg.src + `TSL_ADDR_W'(ia);
                s_next.st       = tsl_pkg::tsl_rdb;
            end
            tsl_pkg::tsl_rdb: begin
                s_next.mem.rd   = vb;
                s_next.mem.addr = s_reg.src + `TSL_ADDR_W'(ib);
                s_next.st       = tsl_pkg::tsl_cap;
            end
            tsl_pkg::tsl_cap: begin
                s_next.wa = va ? mem_rdata : '0;
                s_next.st = tsl_pkg::tsl_wrt;
            end
            tsl_pkg::tsl_wrt: begin
                s_next.wb        = vb ? mem_rdata : '0;
                s_next.st        = tsl_pkg::tsl_rda;
                s_next.mem.we    = 1'b0;
                s_next.st        = tsl_pkg::tsl_done;
            end
            tsl_pkg::tsl_done: begin
                s_next.st   = tsl_pkg::tsl_idle;
                s_next.busy = 1'b0;
                if (s_reg.busy && s_reg.wcnt != {1'b0, s_reg.len}) begin
                    // One word written per pass, then back for the next
                    s_next.mem.we    = 1'b1;
                    s_next.mem.addr  = (is_shift ? s_reg.src : s_reg.dst) + `TSL_ADDR_W'(kk);
                    s_next.mem.wdata = word;
                    s_next.wcnt      = s_reg.wcnt + `TSL_LEN_W'(1);
                    s_next.busy      = 1'b1;
                    s_next.st        = tsl_pkg::tsl_rda;
                    s_next.k         = is_left ? s_reg.k - `TSL_LEN_W'(1)
                                               : s_reg.k + `TSL_LEN_W'(1);
                    if (last) begin
                        s_next.st   = tsl_pkg::tsl_done;
                        s_next.done = 1'b1;
                        if (is_shift) begin
                            // Flag update comes after the scan-end clear, so it wins
                            s_next.flags.range_error_flag   = ({1'b0, s_reg.cnt} > tot_bits);
                            s_next.flags.discarded_one_flag = s_reg.pbit;
                        end
                    end
                end
            end
            default: begin
                s_next.st = tsl_pkg::tsl_idle;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign mem   = s_reg.mem;
    assign busy  = s_reg.busy;
    assign done  = s_reg.done;
    assign flags = s_reg.flags;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    done_single_a: assert property (@(posedge ref_clk) disable iff (rst)
        done |=> !done) else $error("done longer than one cycle");

    word_count_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && s_reg.len != '0 |-> s_reg.wcnt == {1'b0, s_reg.len})
        else $error("word count differs from table length");

    range_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && is_shift |-> flags.range_error_flag == ({1'b0, s_reg.cnt} > tot_bits))
        else $error("range flag wrong at completion");

    zero_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && is_shift && s_reg.cnt == '0 |-> !flags.discarded_one_flag)
        else $error("zero shift left discarded flag set");

    scan_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        scan_end && !s_next.done |=> flags == '0)
        else $error("flags survived scan end");

    and_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        mem.we && s_reg.op == tsl_pkg::tsl_masked_and_copy |-> (mem.wdata & ~s_reg.pat) == '0)
        else $error("and copy set bits outside pattern");

    or_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        mem.we && s_reg.op == tsl_pkg::tsl_masked_or_copy |-> (mem.wdata & s_reg.pat) == s_reg.pat)
        else $error("or copy lost pattern bits");

    xor_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        mem.we && s_reg.op == tsl_pkg::tsl_masked_xor_copy && $past(s_reg.mem.rd, 4)
        |-> mem.wdata == (s_reg.pat ^ $past(mem_rdata, 3)))
        else $error("xor copy word wrong");

    copy_flags_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && !is_shift && !$past(scan_end) |-> $stable(flags))
        else $error("copy changed status flags");

    overrange_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && is_shift && ({1'b0, s_reg.cnt} > tot_bits) |-> !flags.discarded_one_flag)
        else $error("discarded flag set on over-range shift");

    empty_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        done && s_reg.len == '0 |-> !mem.we)
        else $error("empty table caused a write");

endmodule : tsl_engine

//--- bench/tsl_mem_model.sv
// Data memory partner answering the engine's word strobes
`timescale 1ns/1ps
`include "tsl_cfg.svh"

module tsl_mem_model (
    // Clock
    ref_clk,
    // Engine side
    mem,
    mem_rdata
);
    input  wire logic                   ref_clk;
    input  wire tsl_pkg::tsl_mem_t      mem;
    output logic [`TSL_WORD_W-1:0]      mem_rdata;

    logic [`TSL_WORD_W-1:0] ram [0:255];

    initial mem_rdata = 16'h5a5a;

    // Data valid one cycle after the strobe; scrambled otherwise so stale reads show up
    always @(posedge ref_clk) begin
        if (mem.rd === 1'b1) begin
            mem_rdata <= ram[mem.addr[7:0]];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem.we === 1'b1) begin
            ram[mem.addr[7:0]] <= mem.wdata;
        end
    end
endmodule : tsl_mem_model

//--- bench/tb_table_shift_and_logic_copy.sv
// Self-checking bench for the table shift and masked copy engine
`timescale 1ns/1ps
`include "tsl_cfg.svh"

module tb_table_shift_and_logic_copy;
    logic                   ref_clk;
    logic                   rst;
    logic                   cmd_valid;
    tsl_pkg::tsl_cmd_t      cmd;
    logic                   scan_end;
    tsl_pkg::tsl_mem_t      mem;
    logic [`TSL_WORD_W-1:0] mem_rdata;
    logic                   busy;
    logic                   done;
    tsl_pkg::tsl_flags_t    flags;
    int                     fail_count;
    int                     samples_checked;
    logic [15:0]            orig [0:4];
    logic [15:0]            expw [0:4];
    logic [15:0]            wr_q [$];

    tsl_engine DUT (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd), .scan_end(scan_end),
                    .mem(mem), .mem_rdata(mem_rdata), .busy(busy), .done(done), .flags(flags));
    tsl_mem_model mdl (.ref_clk(ref_clk), .mem(mem), .mem_rdata(mem_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (mem.we === 1'b1) begin
            wr_q.push_back(mem.addr);
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("Counts: %0d compared, %0d mismatched", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask : check

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1) begin
            @(negedge ref_clk);
            n++;
            if (n > 4000) begin
                check({15'h0000, done}, 16'h0001);
                end_of_test();
            end
        end
        @(negedge ref_clk);
    endtask : wait_done

    // Called at a falling edge while idle; one-cycle enable so it runs once
    task automatic run(input tsl_pkg::tsl_op_t op, input logic [7:0] len, input logic [15:0] pat,
                       input logic [15:0] opnd);
        wr_q.delete();
        cmd.op          = op;
        cmd.stack_len   = len;
        cmd.acc_start   = 16'h0040;
        cmd.acc_pattern = pat;
        cmd.operand     = opnd;
        cmd_valid       = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        wait_done();
    endtask : run

    function automatic logic [15:0] oct(input int n);
        return {1'b0, 3'(n / 512), 1'b0, 3'(n / 64), 1'b0, 3'(n / 8), 1'b0, 3'(n)};
    endfunction : oct

    task automatic shift_case(input logic left, input int len, input int c);
        int  tot;
        int  s;
        logic dis;
        tot = len * 16;
        for (int i = 0; i < len; i++) mdl.ram[8'h40 + i] = orig[i];
        run(left ? tsl_pkg::tsl_table_bit_shift_left : tsl_pkg::tsl_table_bit_shift_right,
            8'(len), 16'h0000, oct(c));
        for (int i = 0; i < tot; i++) begin
            s = left ? i - c : i + c;
            expw[i / 16][i % 16] = (s >= 0 && s < tot) ? orig[s / 16][s % 16] : 1'b0;
        end
        s   = left ? tot - c : c - 1;
        dis = (c >= 1 && c <= tot) ? orig[s / 16][s % 16] : 1'b0;
        if (c <= tot) begin
            for (int i = 0; i < len; i++) check(mdl.ram[8'h40 + i], expw[i]);
        end
        check({15'h0000, flags.range_error_flag}, {15'h0000, 1'(c > tot)});
        check({15'h0000, flags.discarded_one_flag}, {15'h0000, dis});
    endtask : shift_case

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_shifts();
        shift_case(1'b0, 5, 12);
        shift_case(1'b1, 3, 17);
        shift_case(1'b1, 3, 0);
        shift_case(1'b0, 3, 48);
        $display("test shifts done");
    endtask : t_shifts

    task automatic t_range_clear();
        shift_case(1'b0, 3, 49);
        scan_end = 1'b1;
        @(negedge ref_clk);
        scan_end = 1'b0;
        @(negedge ref_clk);
        check({14'h0000, flags}, 16'h0000);
        $display("test range_clear done");
    endtask : t_range_clear

    task automatic t_copies();
        logic [15:0] pat;
        for (int k = 0; k < 3; k++) begin
            pat = (k == 0) ? 16'h6666 : (k == 1) ? 16'h8888 : 16'h3333;
            mdl.ram[8'h40] = orig[0];
            mdl.ram[8'h41] = orig[1];
            mdl.ram[8'h82] = 16'hbeef;
            run(tsl_pkg::tsl_op_t'(k + 2), 8'h02, pat, 16'h0080);
            for (int i = 0; i < 2; i++) begin
                check(mdl.ram[8'h80 + i], (k == 0) ? orig[i] & pat : (k == 1) ? orig[i] | pat : orig[i] ^ pat);
                check(wr_q[i], 16'h0080 + 16'(i));
            end
            check(16'(wr_q.size()), 16'h0002);
            check(mdl.ram[8'h82], 16'hbeef);
        end
        run(tsl_pkg::tsl_masked_or_copy, 8'h00, 16'hffff, 16'h0082);
        check(16'(wr_q.size()), 16'h0000);
        $display("test copies done");
    endtask : t_copies

    // Held enable repeats; OR copy is idempotent so extra runs leave the same result
    task automatic t_level();
        int runs;
        int n;
        mdl.ram[8'h40] = orig[2];
        cmd.op         = tsl_pkg::tsl_masked_or_copy;
        cmd.stack_len  = 8'h01;
        cmd.acc_start  = 16'h0040;
        cmd.acc_pattern = 16'h0101;
        cmd.operand    = 16'h0090;
        cmd_valid      = 1'b1;
        runs = 0;
        n    = 0;
        while (runs < 2 && n < 4000) begin
            @(negedge ref_clk);
            n++;
            if (done === 1'b1) runs++;
        end
        cmd_valid = 1'b0;
        check(16'(runs), 16'h0002);
        // No done follows once the enable drops, so wait a fixed two cycles
        repeat (2) @(negedge ref_clk);
        check({15'h0000, busy}, 16'h0000);
        check(mdl.ram[8'h90], orig[2] | 16'h0101);
        $display("test level done");
    endtask : t_level

    initial begin
        rst             = 1'b1;
        cmd_valid       = 1'b0;
        cmd             = '0;
        scan_end        = 1'b0;
        fail_count      = 0;
        samples_checked = 0;
        orig[0] = 16'h1234;
        orig[1] = 16'hfedc;
        orig[2] = 16'h9abc;
        orig[3] = 16'hdef0;
        orig[4] = 16'h0a0b;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        check({13'h0000, busy, flags}, 16'h0000);
        t_shifts();
        t_range_clear();
        t_copies();
        t_level();
        end_of_test();
    end
endmodule : tb_table_shift_and_logic_copy
